// *** pkg/hps_pkg.sv ***
// shared constants and types for the parallel host port synchronisation logic
package hps_pkg;

    // ****************************************************************
    // host register selects (3-bit host address)
    // ****************************************************************
    localparam logic [2:0] HPS_SEL_CTRL   = 3'h0;
    localparam logic [2:0] HPS_SEL_CMD    = 3'h1;
    localparam logic [2:0] HPS_SEL_STATUS = 3'h2;
    localparam logic [2:0] HPS_SEL_TXH    = 3'h5;
    localparam logic [2:0] HPS_SEL_TXM    = 3'h6;
    localparam logic [2:0] HPS_SEL_TXL    = 3'h7;

    // ****************************************************************
    // interface control register fields
    // ****************************************************************
    localparam int HPS_CTRL_RREQ = 0;
    localparam int HPS_CTRL_TREQ = 1;
    localparam int HPS_CTRL_HM0  = 5;
    localparam int HPS_CTRL_HM1  = 6;
    localparam int HPS_CTRL_INIT = 7;
    localparam logic [7:0] HPS_CTRL_RST = 8'h00;

    // command register: bit 7 is the pending command, low bits the vector
    localparam int HPS_CMD_HC = 7;
    localparam logic [6:0] HPS_VEC_RST = 7'h00;

    // ****************************************************************
    // timing: figures in T (one core clock), cycles derived at 40 MHz
    // ****************************************************************
    localparam int HPS_CLK_NS       = 25;
    localparam int HPS_T_NS         = 25;
    localparam int HPS_SYNC_T       = 3;
    localparam int HPS_EXEC_T       = 3;
    localparam int HPS_SYNC_CYC     = (HPS_SYNC_T * HPS_T_NS + HPS_CLK_NS - 1) / HPS_CLK_NS;
    localparam int HPS_EXEC_CYC     = (HPS_EXEC_T * HPS_T_NS + HPS_CLK_NS - 1) / HPS_CLK_NS;

    // ****************************************************************
    // status byte as the host reads it
    // ****************************************************************
    typedef struct packed {
        logic host_command_pending;
        logic host_request_line;
        logic dma_active;
        logic host_flag_b;
        logic host_flag_a;
        logic transmitter_ready_flag;
        logic tx_empty_flag;
        logic rx_full_flag;
    } hps_status_s;

    // idle status: transmit empty and ready, so the snapshot does not jump after reset
    localparam logic [7:0] HPS_STATUS_RST = 8'h06;

endpackage

// *** verilog/hps_sync2.sv ***
// two-flop level synchroniser, one per bit, no pairing between bits
`timescale 1ns/1ps
`default_nettype none
module hps_sync2 #(
    parameter int         WIDTH   = 1,
    parameter logic [7:0] RST_VAL = 8'h00
) (
    input  wire logic             sys_clk,
    input  wire logic             sys_rst,
    input  wire logic [WIDTH-1:0] d_in,
    output logic      [WIDTH-1:0] d_out
);
    logic [WIDTH-1:0] meta_q;

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            meta_q <= RST_VAL[WIDTH-1:0];
            d_out  <= RST_VAL[WIDTH-1:0];
        end else begin
            meta_q <= d_in;
            d_out  <= meta_q;
        end
    end
endmodule
`default_nettype wire

// *** verilog/hps_host_port.sv ***
// parallel host port: strobe sync, status blocking, command, transmit path, channel init
// ****************************************************************
// ****************************************************************
`timescale 1ns/1ps
`default_nettype none
module hps_host_port
    import hps_pkg::*;
#(
    parameter int VEC_W = 7
) (
    input  wire logic              sys_clk,
    input  wire logic              sys_rst,
    input  wire logic              host_enable_strobe_n,
    input  wire logic              host_write,
    input  wire logic [2:0]        host_addr,
    input  wire logic [7:0]        host_wdata,
    output logic      [7:0]        host_rdata_q,
    output logic                   host_request_line_n_q,
    input  wire logic              core_flag_a,
    input  wire logic              core_flag_b,
    input  wire logic              core_rx_read,
    input  wire logic              core_hc_ack,
    output logic      [23:0]       core_receive_word_q,
    output logic                   core_rx_full_q,
    output logic                   core_hc_req_q,
    output logic      [VEC_W-1:0]  core_vector_q,
    output hps_status_s            host_status_q
);
    // ****************************************************************
    // strobe synchroniser and edge
    // ****************************************************************
    logic       en_n_s;
    logic       en_prev_q;
    logic [2:0] addr_q;
    logic [7:0] wdata_q;
    logic       wr_q;
    logic [1:0] flags_s;

    hps_sync2 #(.WIDTH(1), .RST_VAL(8'h01)) u_en_sync (
        .sys_clk (sys_clk),
        .sys_rst (sys_rst),
        .d_in    (host_enable_strobe_n),
        .d_out   (en_n_s)
    );

    // flags cross independently, so a 00 to 11 change may read 01 or 10
    hps_sync2 #(.WIDTH(2), .RST_VAL(8'h00)) u_flag_sync (
        .sys_clk (sys_clk),
        .sys_rst (sys_rst),
        .d_in    ({core_flag_b, core_flag_a}),
        .d_out   (flags_s)
    );

    logic en_act;
    logic wr_take;
    assign en_act  = ~en_n_s;
    assign wr_take = en_prev_q & ~en_act & wr_q;

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            en_prev_q <= 1'b0;
            addr_q    <= 3'h0;
            wdata_q   <= 8'h00;
            wr_q      <= 1'b0;
        end else begin
            en_prev_q <= en_act;
            if (en_act) begin
                addr_q  <= host_addr;
                wdata_q <= host_wdata;
                wr_q    <= host_write;
            end
        end
    end

    // ****************************************************************
    // control register and channel initialisation
    // ****************************************************************
    logic [7:0] ctrl_q;
    logic [2:0] init_cnt_q;
    logic       init_start;
    assign init_start = wr_take && addr_q == HPS_SEL_CTRL && wdata_q[HPS_CTRL_INIT];

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ctrl_q     <= HPS_CTRL_RST;
            init_cnt_q <= 3'h0;
        end else if (wr_take && addr_q == HPS_SEL_CTRL) begin
            ctrl_q     <= wdata_q;
            init_cnt_q <= wdata_q[HPS_CTRL_INIT] ? 3'(HPS_EXEC_CYC) : 3'h0;
        end else if (init_cnt_q != 3'h0) begin
            init_cnt_q <= init_cnt_q - 3'h1;
            if (init_cnt_q == 3'h1) begin
                ctrl_q[HPS_CTRL_INIT] <= 1'b0;
            end
        end
    end

    logic init_busy;
    assign init_busy = ctrl_q[HPS_CTRL_INIT];

    // ****************************************************************
    // host command and vector
    // ****************************************************************
    logic             hc_q;
    logic [VEC_W-1:0] vec_q;

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            hc_q  <= 1'b0;
            vec_q <= HPS_VEC_RST[VEC_W-1:0];
        end else if (wr_take && addr_q == HPS_SEL_CMD) begin
            hc_q  <= wdata_q[HPS_CMD_HC];
            vec_q <= wdata_q[VEC_W-1:0];
        end else if (core_hc_ack) begin
            hc_q  <= 1'b0;
        end
    end

    // one stage late: an ack can follow a host cancel, which the core must tolerate
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            core_hc_req_q <= 1'b0;
            core_vector_q <= HPS_VEC_RST[VEC_W-1:0];
        end else begin
            core_hc_req_q <= hc_q & ~core_hc_ack;
            core_vector_q <= vec_q;
        end
    end

    // ****************************************************************
    // transmit bytes to core receive word
    // ****************************************************************
    logic [23:0] tx_q;
    logic        tx_empty_q;
    logic        do_xfer;
    assign do_xfer = ~tx_empty_q & ~core_rx_full_q;

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            tx_q       <= 24'h000000;
            tx_empty_q <= 1'b1;
        end else if (init_start) begin
            tx_empty_q <= 1'b1;
        end else begin
            if (wr_take && addr_q == HPS_SEL_TXH) tx_q[23:16] <= wdata_q;
            if (wr_take && addr_q == HPS_SEL_TXM) tx_q[15:8]  <= wdata_q;
            if (wr_take && addr_q == HPS_SEL_TXL) begin
                tx_q[7:0]  <= wdata_q;
                tx_empty_q <= 1'b0;
            end else if (do_xfer) begin
                tx_empty_q <= 1'b1;
            end
        end
    end

    // a transfer in the same cycle as a core read wins, so no word is lost
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            core_receive_word_q <= 24'h000000;
            core_rx_full_q      <= 1'b0;
        end else if (do_xfer) begin
            core_receive_word_q <= tx_q;
            core_rx_full_q      <= 1'b1;
        end else if (core_rx_read) begin
            core_rx_full_q      <= 1'b0;
        end
    end

    // ****************************************************************
    // live status, blocking snapshot, read data, request line
    // ****************************************************************
    hps_status_s live_status;
    logic        req_live;
    assign req_live = ctrl_q[HPS_CTRL_TREQ] & tx_empty_q & ~init_busy;

    always_comb begin
        live_status.host_command_pending   = hc_q;
        live_status.host_request_line      = req_live;
        live_status.dma_active             = ctrl_q[HPS_CTRL_HM1] | ctrl_q[HPS_CTRL_HM0];
        live_status.host_flag_b            = flags_s[1];
        live_status.host_flag_a            = flags_s[0];
        live_status.transmitter_ready_flag = tx_empty_q & ~core_rx_full_q;
        live_status.tx_empty_flag          = tx_empty_q;
        live_status.rx_full_flag           = core_rx_full_q;
    end

    // snapshot refreshes only while the strobe is idle; a read holds it still
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            host_status_q <= hps_status_s'(HPS_STATUS_RST);
        end else if (!en_act) begin
            host_status_q <= live_status;
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            host_rdata_q          <= 8'h00;
            host_request_line_n_q <= 1'b1;
        end else begin
            host_request_line_n_q <= ~req_live;
            case (host_addr)
                HPS_SEL_CTRL:   host_rdata_q <= ctrl_q;
                HPS_SEL_CMD:    host_rdata_q <= {hc_q, vec_q};
                HPS_SEL_STATUS: host_rdata_q <= host_status_q;
                default:        host_rdata_q <= 8'h00;
            endcase
        end
    end

    // ****************************************************************
    // checks
    // ****************************************************************
    localparam int EXEC_MAX = HPS_EXEC_CYC;

    sequence s_held_read;
        en_act ##1 en_act;
    endsequence

    chk_status_frozen: assert property (@(posedge sys_clk) disable iff (sys_rst)
        s_held_read |-> $stable(host_status_q))
        else $error("status snapshot moved during held strobe");

    chk_status_refresh: assert property (@(posedge sys_clk) disable iff (sys_rst)
        !en_act |=> host_status_q == $past(live_status))
        else $error("status snapshot not refreshed while idle");

    sequence s_init_write;
        init_start ##1 init_busy;
    endsequence

    chk_init_clears: assert property (@(posedge sys_clk) disable iff (sys_rst)
        s_init_write |-> ##[1:EXEC_MAX] !init_busy)
        else $error("initialize bit not cleared in time");

    chk_init_total: assert property (@(posedge sys_clk) disable iff (sys_rst)
        $fell(en_act) && wr_q && addr_q == HPS_SEL_CTRL && wdata_q[HPS_CTRL_INIT]
        |-> ##4 !init_busy)
        else $error("initialization exceeded its bound");

    chk_flag_path: assert property (@(posedge sys_clk) disable iff (sys_rst)
        ##2 flags_s[0] == $past(core_flag_a, 2))
        else $error("flag a synchroniser depth wrong");

    chk_hc_follow: assert property (@(posedge sys_clk) disable iff (sys_rst)
        hc_q && !core_hc_ack |=> core_hc_req_q)
        else $error("command request not passed to core");

    chk_xfer_word: assert property (@(posedge sys_clk) disable iff (sys_rst)
        do_xfer |=> core_rx_full_q && core_receive_word_q == $past(tx_q))
        else $error("transmit word not moved to core");

    chk_rx_set_wins: assert property (@(posedge sys_clk) disable iff (sys_rst)
        do_xfer && core_rx_read |=> core_rx_full_q)
        else $error("receive-full lost on simultaneous read");

endmodule
`default_nettype wire

// *** sim/hps_host_model.sv ***
// host processor model driving the asynchronous host bus
`timescale 1ns/1ps
`default_nettype none
module hps_host_model
    import hps_pkg::*;
(
    input  wire logic       sys_clk,
    input  wire logic [7:0] host_rdata_q,
    output logic            host_enable_strobe_n,
    output logic            host_write,
    output logic      [2:0] host_addr,
    output logic      [7:0] host_wdata
);
    initial begin
        host_enable_strobe_n = 1'b1;
        host_write           = 1'b0;
        host_addr            = 3'h3;
        host_wdata           = 8'h00;
    end

    // ****************************************************************
    // bus cycles
    // ****************************************************************
    task automatic cycle(input logic wr, input logic [2:0] a, input logic [7:0] d, input int hold,
                         output logic [7:0] q);
        @(posedge sys_clk);
        host_enable_strobe_n <= 1'b0;
        host_write           <= wr;
        host_addr            <= a;
        host_wdata           <= d;
        repeat (hold) @(posedge sys_clk);
        q = host_rdata_q;
        host_enable_strobe_n <= 1'b1;
        // qualifiers held until the synchronised strobe rises
        repeat (2) @(posedge sys_clk);
        host_write <= ~wr;
        host_addr  <= ~a;
        host_wdata <= ~d;
        // strobe stays high so the status snapshot refreshes
        repeat ((wr && a == HPS_SEL_CTRL) ? 4 : 2) @(posedge sys_clk);
        #1;
    endtask

    task automatic put_word(input logic [23:0] w);
        logic [7:0] s;
        s = 8'h00;
        for (int n = 0; n < 8 && s[1] !== 1'b1; n++) begin
            cycle(1'b0, HPS_SEL_STATUS, 8'h00, 3, s);
        end
        cycle(1'b1, HPS_SEL_TXH, w[23:16], 3, s);
        cycle(1'b1, HPS_SEL_TXM, w[15:8], 3, s);
        cycle(1'b1, HPS_SEL_TXL, w[7:0], 3, s);
    endtask

    task automatic init_channel(input logic [7:0] ctrl, output logic [7:0] q);
        cycle(1'b1, HPS_SEL_CTRL, ctrl, 3, q);
        q = 8'h80;
        for (int n = 0; n < 4 && q[HPS_CTRL_INIT] !== 1'b0; n++) begin
            cycle(1'b0, HPS_SEL_CTRL, 8'h00, 3, q);
        end
    endtask
endmodule
`default_nettype wire

// *** sim/testbench.sv ***
// self-checking bench for the host port synchronisation logic
`timescale 1ns/1ps
`default_nettype none
module testbench
    import hps_pkg::*;
;
    typedef struct packed {
        logic [23:0] word;
        logic [6:0]  vec;
    } hps_row_s;
    localparam hps_row_s ROWS [4] = '{'{24'h123456, 7'h00}, '{24'hffffff, 7'h7f},
                                      '{24'h000000, 7'h2a}, '{24'ha5c33c, 7'h55}};
    logic        sys_clk;
    logic        sys_rst;
    logic        host_enable_strobe_n;
    logic        host_write;
    logic [2:0]  host_addr;
    logic [7:0]  host_wdata;
    logic [7:0]  host_rdata_q;
    logic        host_request_line_n_q;
    logic        core_flag_a;
    logic        core_flag_b;
    logic        core_rx_read;
    logic        core_hc_ack;
    logic [23:0] core_receive_word_q;
    logic        core_rx_full_q;
    logic        core_hc_req_q;
    logic [6:0]  core_vector_q;
    hps_status_s host_status_q;
    logic [7:0]  q;
    int          miscompares;
    int          check_count;

    hps_host_port i_dut (.sys_clk, .sys_rst, .host_enable_strobe_n, .host_write, .host_addr, .host_wdata,
        .host_rdata_q, .host_request_line_n_q, .core_flag_a, .core_flag_b, .core_rx_read, .core_hc_ack,
        .core_receive_word_q, .core_rx_full_q, .core_hc_req_q, .core_vector_q, .host_status_q);
    hps_host_model i_host (.sys_clk, .host_rdata_q, .host_enable_strobe_n, .host_write, .host_addr,
        .host_wdata);

    // ****************************************************************
    // checking helpers
    // ****************************************************************
    task automatic cmp_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic cmp_word(input string what, input logic [23:0] exp, input logic [23:0] got);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic core_pulse(input logic ack);
        @(posedge sys_clk);
        core_rx_read <= ~ack;
        core_hc_ack  <= ack;
        @(posedge sys_clk);
        core_rx_read <= 1'b0;
        core_hc_ack  <= 1'b0;
        repeat (2) @(posedge sys_clk);
        #1;
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end

    // a full run needs well under a tenth of this
    initial begin
        repeat (20000) @(posedge sys_clk);
        miscompares++;
        print_verdict();
    end

    initial begin
        sys_rst      = 1'b1;
        core_flag_a  = 1'b0;
        core_flag_b  = 1'b0;
        core_rx_read = 1'b0;
        core_hc_ack  = 1'b0;
        miscompares  = 0;
        check_count  = 0;
        repeat (16) @(posedge sys_clk);
        sys_rst <= 1'b0;
        @(posedge sys_clk);
        #1;
        cmp_byte("status", HPS_STATUS_RST, host_status_q);
        cmp_byte("request_n", 8'h01, {7'h00, host_request_line_n_q});
        i_host.cycle(1'b0, HPS_SEL_CTRL, 8'h00, 3, q);
        cmp_byte("ctrl", HPS_CTRL_RST, q);
        i_host.init_channel(8'h82, q);
        cmp_byte("ctrl init", 8'h02, q);
        cmp_byte("request_n", 8'h00, {7'h00, host_request_line_n_q});
        foreach (ROWS[i]) begin
            i_host.put_word(ROWS[i].word);
            cmp_word("rx word", ROWS[i].word, core_receive_word_q);
            cmp_byte("rx full", 8'h01, {7'h00, core_rx_full_q});
            i_host.cycle(1'b1, HPS_SEL_CMD, {1'b1, ROWS[i].vec}, 3, q);
            cmp_byte("vector", {1'b0, ROWS[i].vec}, {1'b0, core_vector_q});
            cmp_byte("hc", 8'h81, {host_status_q.host_command_pending, 6'h00, core_hc_req_q});
            core_pulse(1'b1);
            cmp_byte("hc ack", 8'h00, {host_status_q.host_command_pending, 6'h00, core_hc_req_q});
            core_pulse(1'b0);
            cmp_byte("rx read", 8'h02, {6'h00, host_status_q.tx_empty_flag, core_rx_full_q});
        end
        // second word waits in the transmit bytes while the core is full
        i_host.put_word(24'h0badf0);
        i_host.put_word(24'h13579b);
        cmp_word("held word", 24'h0badf0, core_receive_word_q);
        cmp_byte("tx empty", 8'h00, {7'h00, host_status_q.tx_empty_flag});
        cmp_byte("request_n", 8'h01, {7'h00, host_request_line_n_q});
        // core read spans the refill, so transfer and read meet in one cycle
        @(posedge sys_clk);
        core_rx_read <= 1'b1;
        repeat (2) @(posedge sys_clk);
        core_rx_read <= 1'b0;
        @(posedge sys_clk);
        #1;
        cmp_word("next word", 24'h13579b, core_receive_word_q);
        cmp_byte("rx full kept", 8'h01, {7'h00, core_rx_full_q});
        core_pulse(1'b0);
        i_host.cycle(1'b1, HPS_SEL_CMD, 8'h91, 3, q);
        i_host.cycle(1'b1, HPS_SEL_CMD, 8'h92, 3, q);
        cmp_byte("vector", 8'h12, {1'b0, core_vector_q});
        i_host.cycle(1'b1, HPS_SEL_CMD, 8'h12, 3, q);
        cmp_byte("cancel", 8'h12, {core_hc_req_q, core_vector_q});
        core_pulse(1'b1);
        cmp_byte("late ack", 8'h00, {host_status_q.host_command_pending, 6'h00, core_hc_req_q});
        fork
            i_host.cycle(1'b0, HPS_SEL_STATUS, 8'h00, 12, q);
            begin
                repeat (5) @(posedge sys_clk);
                core_flag_a <= 1'b1;
                core_flag_b <= 1'b1;
                repeat (4) @(posedge sys_clk);
                #1;
                cmp_byte("frozen", 8'h00, {6'h00, host_status_q.host_flag_b, host_status_q.host_flag_a});
            end
        join
        cmp_byte("read flags", 8'h00, {6'h00, q[4:3]});
        i_host.cycle(1'b0, HPS_SEL_STATUS, 8'h00, 3, q);
        cmp_byte("flag pair", 8'h03, {6'h00, q[4:3]});
        i_host.cycle(1'b0, HPS_SEL_STATUS, 8'h00, 3, q);
        cmp_byte("flag agree", 8'h03, {6'h00, q[4:3]});
        print_verdict();
    end
endmodule
`default_nettype wire
